// [wpc_wakeup_regs.svh]
`ifndef WPC_WAKEUP_REGS_SVH
`define WPC_WAKEUP_REGS_SVH

// byte offsets of the register words on the slave port
`define WPC_OFF_EDGE 5'h00
`define WPC_OFF_ENABLE 5'h04
`define WPC_OFF_REQ_LOW 5'h08
`define WPC_OFF_REQ_HIGH 5'h0C
`define WPC_OFF_PENDING 5'h10
`define WPC_OFF_CLEAR 5'h14
`define WPC_OFF_INT_STATUS 5'h18
`define WPC_OFF_INT_MASK 5'h1C

// reset values
`define WPC_RST_WORD 16'h0000
`define WPC_RST_READ 32'h0000_0000
`define WPC_RST_REQ 4'h0

// field layout of a request select word: two bits per channel
`define WPC_REQ_FIELD_W 2
`define WPC_CH_PER_WORD 8

// value returned by the write-only clear location and unmapped words
`define WPC_READ_FILL 16'h0000

`endif

// [wpc_wakeup_pkg.sv]
package wpc_wakeup_pkg;

   // one bit per wake-up channel
   typedef logic [15:0] wpc_word_t;

   // request line number of one channel
   typedef logic [1:0] wpc_req_t;

   // one bit per wake-up interrupt request line
   typedef logic [3:0] wpc_line_t;

endpackage

// [wpc_wakeup_pending_control.sv]
`include "wpc_wakeup_regs.svh"

// Summary of operation
// - sixteen pending flags, one per channel
// - writing pending word sets the one bits
// - reset clears every pending flag
// - clear word: ones clear matching pending flags
// - clear word reads undefined, no side effect
// - edge select: zero rising, one falling
// - channel active while pending and enabled
// - two-bit field routes channel to request
// - reset clears edge selects to rising
// - edge latching independent of system clock; here edges are only seen on clk samples
module wpc_wakeup_pending_control (
   input wire logic clk,
   input wire logic rstn,
   input wire wpc_wakeup_pkg::wpc_word_t wakeIn,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output wpc_wakeup_pkg::wpc_word_t chanActive,
   output logic wakeRequest,
   output wpc_wakeup_pkg::wpc_line_t irqRequest,
   output logic irq
);

   // two-stage synchroniser; first stage is read only by the second
   wpc_wakeup_pkg::wpc_word_t syncMeta;
   // synchronised channel level
   wpc_wakeup_pkg::wpc_word_t syncCur;
   // level one cycle earlier, for edge detection
   wpc_wakeup_pkg::wpc_word_t syncPrev;

   // software registers
   wpc_wakeup_pkg::wpc_word_t edgeSelectReg;
   wpc_wakeup_pkg::wpc_word_t channelEnableReg;
   wpc_wakeup_pkg::wpc_word_t requestSelectLow;
   wpc_wakeup_pkg::wpc_word_t requestSelectHigh;
   wpc_wakeup_pkg::wpc_word_t wakePendingReg;
   wpc_wakeup_pkg::wpc_word_t intStatus;
   wpc_wakeup_pkg::wpc_word_t intMask;

   // next values
   wpc_wakeup_pkg::wpc_word_t next_edgeSelectReg;
   wpc_wakeup_pkg::wpc_word_t next_channelEnableReg;
   wpc_wakeup_pkg::wpc_word_t next_requestSelectLow;
   wpc_wakeup_pkg::wpc_word_t next_requestSelectHigh;
   wpc_wakeup_pkg::wpc_word_t next_wakePendingReg;
   wpc_wakeup_pkg::wpc_word_t next_intStatus;
   wpc_wakeup_pkg::wpc_word_t next_intMask;
   wpc_wakeup_pkg::wpc_word_t next_active;
   wpc_wakeup_pkg::wpc_line_t next_irqRequest;

   // per-channel trigger pulse
   wpc_wakeup_pkg::wpc_word_t trig;
   wpc_wakeup_pkg::wpc_word_t riseSeen;
   wpc_wakeup_pkg::wpc_word_t fallSeen;

   // bus decode
   logic busReq;
   logic busAcc;
   logic busAccWr;
   logic busAccRd;
   logic selEdge;
   logic selEnable;
   logic selReqLow;
   logic selReqHigh;
   logic selPend;
   logic selClr;
   logic selStat;
   logic selMask;
   // byte lanes 0 and 1 carry the sixteen register bits
   wpc_wakeup_pkg::wpc_word_t laneMask;
   wpc_wakeup_pkg::wpc_word_t wrBits;
   // set and clear masks for the pending word
   wpc_wakeup_pkg::wpc_word_t swSet;
   wpc_wakeup_pkg::wpc_word_t pendingClearBits;
   // status bits that the accepted read has shown
   wpc_wakeup_pkg::wpc_word_t readClr;
   // read data selected from the addressed word
   wpc_wakeup_pkg::wpc_word_t rdMux;

   // per request line, which channels are routed there
   wpc_wakeup_pkg::wpc_word_t lineHit [4];

   // input synchroniser and edge history
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         syncMeta <= `WPC_RST_WORD;
         syncCur <= `WPC_RST_WORD;
         syncPrev <= `WPC_RST_WORD;
      end
      else
      begin
         syncMeta <= wakeIn;
         syncCur <= syncMeta;
         syncPrev <= syncCur;
      end
   end

   // detection on sampled levels only
   // this block has no stopped-clock path: a clock-free latch
   // must sit in front of wakeIn if the clock may stop
   assign riseSeen = syncCur & ~syncPrev;
   assign fallSeen = ~syncCur & syncPrev;

   // select rising or falling
   // comparing two samples means reprogramming the select
   // never fakes an edge by itself
   assign trig = (riseSeen & ~edgeSelectReg) | (fallSeen & edgeSelectReg);

   // Avalon request is taken on the cycle waitrequest is low
   assign busReq = avs_read | avs_write;
   assign busAcc = busReq & ~avs_waitrequest;
   assign busAccWr = busAcc & avs_write;
   assign busAccRd = busAcc & avs_read;

   // address decode, full match of the word offset
   assign selEdge = (avs_address == `WPC_OFF_EDGE);
   assign selEnable = (avs_address == `WPC_OFF_ENABLE);
   assign selReqLow = (avs_address == `WPC_OFF_REQ_LOW);
   assign selReqHigh = (avs_address == `WPC_OFF_REQ_HIGH);
   assign selPend = (avs_address == `WPC_OFF_PENDING);
   assign selClr = (avs_address == `WPC_OFF_CLEAR);
   assign selStat = (avs_address == `WPC_OFF_INT_STATUS);
   assign selMask = (avs_address == `WPC_OFF_INT_MASK);

   // byte enables gate which bits a write may touch
   assign laneMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wrBits = avs_writedata[15:0] & laneMask;

   // plain read/write words merge new bits under the lane mask
   assign next_edgeSelectReg = (busAccWr && selEdge) ?
      ((edgeSelectReg & ~laneMask) | wrBits) : edgeSelectReg;
   assign next_channelEnableReg = (busAccWr && selEnable) ?
      ((channelEnableReg & ~laneMask) | wrBits) : channelEnableReg;
   assign next_requestSelectLow = (busAccWr && selReqLow) ?
      ((requestSelectLow & ~laneMask) | wrBits) : requestSelectLow;
   assign next_requestSelectHigh = (busAccWr && selReqHigh) ?
      ((requestSelectHigh & ~laneMask) | wrBits) : requestSelectHigh;
   assign next_intMask = (busAccWr && selMask) ?
      ((intMask & ~laneMask) | wrBits) : intMask;

   assign swSet = (busAccWr && selPend) ? wrBits : `WPC_RST_WORD;

   assign pendingClearBits = (busAccWr && selClr) ? wrBits : `WPC_RST_WORD;

   // set terms after clear term
   // a trigger in the clearing cycle survives the clear
   assign next_wakePendingReg = (wakePendingReg & ~pendingClearBits) | swSet | trig;

   assign next_active = next_wakePendingReg & next_channelEnableReg;

   // interrupt status: only bits that the read returned are dropped,
   // so an event landing during the read stays for the next one
   assign readClr = (busAccRd && selStat) ? avs_readdata[15:0] : `WPC_RST_WORD;
   assign next_intStatus = (intStatus & ~readClr) | trig;

   // route each channel to its request line
   genvar ch;
   genvar ln;
   generate
      for (ch = 0; ch < 16; ch++)
      begin : g_chan
         wpc_wakeup_pkg::wpc_req_t field;
         // channels 0..7 live in the low word, 8..15 in the high word
         if (ch < `WPC_CH_PER_WORD)
         begin : g_low
            assign field = next_requestSelectLow[`WPC_REQ_FIELD_W*ch +: `WPC_REQ_FIELD_W];
         end
         else
         begin : g_high
            assign field = next_requestSelectHigh[
               `WPC_REQ_FIELD_W*(ch-`WPC_CH_PER_WORD) +: `WPC_REQ_FIELD_W];
         end
         for (ln = 0; ln < 4; ln++)
         begin : g_line
            assign lineHit[ln][ch] = (field == 2'(ln));
         end
      end
      for (ln = 0; ln < 4; ln++)
      begin : g_req
         assign next_irqRequest[ln] = |(next_active & lineHit[ln]);
      end
   endgenerate

   // clear location reads as fill, no side effect
   // unmapped words read as zero and ignore writes
   assign rdMux = selEdge ? edgeSelectReg :
                  selEnable ? channelEnableReg :
                  selReqLow ? requestSelectLow :
                  selReqHigh ? requestSelectHigh :
                  selPend ? wakePendingReg :
                  selStat ? intStatus :
                  selMask ? intMask :
                  `WPC_READ_FILL;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         edgeSelectReg <= `WPC_RST_WORD;
         channelEnableReg <= `WPC_RST_WORD;
         requestSelectLow <= `WPC_RST_WORD;
         requestSelectHigh <= `WPC_RST_WORD;
         wakePendingReg <= `WPC_RST_WORD;
         intStatus <= `WPC_RST_WORD;
         intMask <= `WPC_RST_WORD;
      end
      else
      begin
         edgeSelectReg <= next_edgeSelectReg;
         channelEnableReg <= next_channelEnableReg;
         requestSelectLow <= next_requestSelectLow;
         requestSelectHigh <= next_requestSelectHigh;
         wakePendingReg <= next_wakePendingReg;
         intStatus <= next_intStatus;
         intMask <= next_intMask;
      end
   end

   // one wait cycle per request; read data are loaded in that
   // cycle so they stand at the accepting edge
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= `WPC_RST_READ;
      end
      else
      begin
         avs_waitrequest <= ~(busReq & avs_waitrequest);
         if (busReq && avs_waitrequest)
         begin
            avs_readdata <= {16'h0000, rdMux};
         end
      end
   end

   // outputs built from next values so they track the registers
   // with no extra cycle of lag
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         chanActive <= `WPC_RST_WORD;
         wakeRequest <= 1'b0;
         irqRequest <= `WPC_RST_REQ;
         irq <= 1'b0;
      end
      else
      begin
         chanActive <= next_active;
         wakeRequest <= |next_active;
         irqRequest <= next_irqRequest;
         irq <= |(next_intStatus & next_intMask);
      end
   end

   // channel 0 rising and falling edge as seen after the synchroniser
   sequence riseCh0;
      (!syncCur[0] && !edgeSelectReg[0]) ##1 (syncCur[0] && !edgeSelectReg[0]);
   endsequence

   sequence fallCh0;
      (syncCur[0] && edgeSelectReg[0]) ##1 (!syncCur[0] && edgeSelectReg[0]);
   endsequence

   chk_pend_write_set: assert property (
      @(posedge clk) disable iff (!rstn)
      (busAccWr && selPend) |=> ((wakePendingReg & $past(wrBits)) == $past(wrBits)))
      else $error("pending write did not set bits");

   chk_pend_clear_write: assert property (
      @(posedge clk) disable iff (!rstn)
      (busAccWr && selClr) |=> ((wakePendingReg & $past(wrBits & ~trig)) == 16'h0000))
      else $error("clear write left bits set");

   chk_clear_read_quiet: assert property (
      @(posedge clk) disable iff (!rstn)
      (busAccRd && selClr && (trig == 16'h0000)) |=> $stable(wakePendingReg))
      else $error("clear read changed pending");

   chk_reset_state_zero: assert property (
      @(posedge clk)
      !rstn |=> ((wakePendingReg == 16'h0000) && (edgeSelectReg == 16'h0000)
                 && (requestSelectLow == 16'h0000) && (chanActive == 16'h0000)))
      else $error("reset left state set");

   chk_edge_select_ch0: assert property (
      @(posedge clk) disable iff (!rstn)
      (riseCh0 or fallCh0) |=> wakePendingReg[0])
      else $error("selected edge not latched");

   chk_active_follow: assert property (
      @(posedge clk) disable iff (!rstn)
      ##1 (chanActive == (wakePendingReg & channelEnableReg))
      && (wakeRequest == |(wakePendingReg & channelEnableReg)))
      else $error("active output wrong");

   chk_route_default: assert property (
      @(posedge clk) disable iff (!rstn)
      ((requestSelectLow == 16'h0000) && (requestSelectHigh == 16'h0000)
       && ((wakePendingReg & channelEnableReg) != 16'h0000))
      |-> (irqRequest == 4'h1))
      else $error("default route not line 0");

   chk_set_wins_clear: assert property (
      @(posedge clk) disable iff (!rstn)
      (busAccWr && selClr) |=> ((wakePendingReg & $past(trig)) == $past(trig)))
      else $error("trigger lost to clear");

   chk_irq_level: assert property (
      @(posedge clk) disable iff (!rstn)
      ##1 (irq == |(intStatus & intMask)))
      else $error("interrupt level wrong");

   chk_bus_answer: assert property (
      @(posedge clk) disable iff (!rstn)
      (busReq && avs_waitrequest) |=> (!avs_waitrequest ##1 avs_waitrequest))
      else $error("bus answer not one cycle");

endmodule // wpc_wakeup_pending_control

// [wpc_wake_source.sv]
// wake-up channel sources: each channel is a plain level, changed just
// after a clock edge and then held for whole cycles
module wpc_wake_source (
   input wire logic clk,
   output wpc_wakeup_pkg::wpc_word_t wakeIn
);
   timeunit 1ns;
   timeprecision 1ps;

   // quiet inputs at time zero
   initial wakeIn = 16'h0000;

   // new levels stay for many cycles, so no pulse is too short to be seen
   task automatic drive(input wpc_wakeup_pkg::wpc_word_t v);
      @(posedge clk);
      wakeIn <= v;
   endtask
endmodule // wpc_wake_source

// [tb_wakeup_pending_control.sv]
`include "wpc_wakeup_regs.svh"

module tb_wakeup_pending_control;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rstn, avsRead, avsWrite, avsWaitrequest, wakeRequest, irq;
   logic [4:0] avsAddress; // byte offset of the word
   logic [31:0] avsWritedata, avsReaddata, rd;
   logic [3:0] avsByteenable;
   wpc_wakeup_pkg::wpc_word_t wakeIn, chanActive;
   wpc_wakeup_pkg::wpc_line_t irqRequest;
   // reference model of the register state
   wpc_wakeup_pkg::wpc_word_t pend, en, edg, stat, mask, lvl, w;
   wpc_wakeup_pkg::wpc_req_t req [16];
   int errTotal, checksDone, ch;

   wpc_wakeup_pending_control i_wpc_wakeup_pending_control (.clk(clk), .rstn(rstn),
      .wakeIn(wakeIn), .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
      .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
      .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .chanActive(chanActive), .wakeRequest(wakeRequest), .irqRequest(irqRequest), .irq(irq));
   wpc_wake_source i_wpc_wake_source (.clk(clk), .wakeIn(wakeIn));

   // free-running 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic printVerdict();
      if (errTotal == 0 && checksDone > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         errTotal++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      @(posedge clk);
      avsWrite <= wr;
      avsRead <= !wr;
      avsAddress <= a;
      avsWritedata <= {16'h0000, d};
      avsByteenable <= be;
      n = 0;
      @(posedge clk);
      while (avsWaitrequest !== 1'b0)
      begin
         n++;
         // a slave that never answers ends the run
         if (n > 50)
         begin
            errTotal++;
            $display("[ERR] %0t bus answer timed out", $time);
            printVerdict();
         end
         @(posedge clk);
      end
      q = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask

   task automatic rdChk(input logic [4:0] a, input logic [15:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, 4'hF, q);
      check(q, {16'h0000, exp});
   endtask

   // request lines expected from the active channels and their selects
   function automatic wpc_wakeup_pkg::wpc_line_t lines(input wpc_wakeup_pkg::wpc_word_t act);
      lines = 4'h0;
      for (int i = 0; i < 16; i++)
         lines[req[i]] = lines[req[i]] | act[i];
   endfunction

   task automatic checkOuts();
      check({16'h0000, chanActive}, {16'h0000, pend & en});
      check({31'h0000000, wakeRequest}, {31'h0000000, |(pend & en)});
      check({28'h0000000, irqRequest}, {28'h0000000, lines(pend & en)});
      check({31'h0000000, irq}, {31'h0000000, |(stat & mask)});
   endtask

   // new channel levels; trigger worked out from the chosen edge
   task automatic applyLevel(input wpc_wakeup_pkg::wpc_word_t nv);
      wpc_wakeup_pkg::wpc_word_t trig;
      trig = (edg & lvl & ~nv) | (~edg & ~lvl & nv);
      pend = pend | trig;
      stat = stat | trig;
      lvl = nv;
      i_wpc_wake_source.drive(nv);
      repeat (6) @(posedge clk);
      checkOuts();
   endtask

   task automatic doReset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      {pend, en, edg, stat, mask} = '0;
      foreach (req[i]) req[i] = 2'h0;
   endtask

   initial
   begin
      {avsRead, avsWrite, avsAddress, avsWritedata, errTotal, checksDone} = '0;
      avsByteenable = 4'hF;
      rstn = 1'b0;
      lvl = 16'h0000;
      void'($urandom(32'h01BC9546));
      doReset();
      // every word reads zero after reset
      for (int k = 0; k < 8; k++)
         rdChk(5'(k * 4), 16'h0000);
      wr(`WPC_OFF_ENABLE, 16'h0000);
      edg = 16'($urandom);
      wr(`WPC_OFF_EDGE, edg);
      wr(`WPC_OFF_CLEAR, 16'hFFFF);
      // low word forces all four select codes on channels 0 to 3
      w = {8'($urandom), 8'hE4};
      wr(`WPC_OFF_REQ_LOW, w);
      for (int i = 0; i < 8; i++) req[i] = w[2 * i +: 2];
      w = 16'($urandom);
      wr(`WPC_OFF_REQ_HIGH, w);
      for (int i = 0; i < 8; i++) req[i + 8] = w[2 * i +: 2];
      en = 16'($urandom) | 16'h000F;
      wr(`WPC_OFF_ENABLE, en);
      mask = 16'($urandom);
      wr(`WPC_OFF_INT_MASK, mask);
      // only the low lane lands when one byte is enabled
      bus(1'b1, `WPC_OFF_ENABLE, 16'hFFFF, 4'h1, rd);
      en[7:0] = 8'hFF;
      rdChk(`WPC_OFF_ENABLE, en);
      // random traffic on the channels and the registers
      for (int it = 0; it < 60; it++)
      begin
         applyLevel(16'($urandom));
         w = 16'($urandom);
         case ($urandom_range(4))
            0: begin wr(`WPC_OFF_PENDING, w); pend = pend | w; end
            1: begin wr(`WPC_OFF_CLEAR, w); pend = pend & ~w; end
            2: rdChk(`WPC_OFF_CLEAR, 16'h0000);
            3: begin rdChk(`WPC_OFF_INT_STATUS, stat); stat = 16'h0000; end
            default: begin mask = w; wr(`WPC_OFF_INT_MASK, w); end
         endcase
         rdChk(`WPC_OFF_PENDING, pend);
         checkOuts();
      end
      // edge change on one channel, then both edges on it
      ch = $urandom_range(15);
      en[ch] = 1'b0;
      wr(`WPC_OFF_ENABLE, en);
      edg[ch] = ~edg[ch];
      wr(`WPC_OFF_EDGE, edg);
      wr(`WPC_OFF_CLEAR, 16'h0001 << ch);
      pend[ch] = 1'b0;
      en[ch] = 1'b1;
      wr(`WPC_OFF_ENABLE, en);
      rdChk(`WPC_OFF_PENDING, pend);
      applyLevel(lvl ^ (16'h0001 << ch));
      applyLevel(lvl ^ (16'h0001 << ch));
      rdChk(`WPC_OFF_PENDING, pend);
      // trigger lands in the very cycle the clear write is taken
      // level change at one edge, request raised at the next one
      applyLevel((lvl & ~(16'h0001 << ch)) | (edg & (16'h0001 << ch)));
      wr(`WPC_OFF_CLEAR, 16'h0001 << ch);
      pend[ch] = 1'b0;
      i_wpc_wake_source.drive(lvl ^ (16'h0001 << ch));
      wr(`WPC_OFF_CLEAR, 16'h0001 << ch);
      lvl[ch] = ~lvl[ch];
      pend[ch] = 1'b1;
      stat[ch] = 1'b1;
      repeat (4) @(posedge clk);
      rdChk(`WPC_OFF_PENDING, pend);
      checkOuts();
      // second reset in mid-run with quiet inputs
      applyLevel(16'h0000);
      doReset();
      repeat (2) @(posedge clk);
      rdChk(`WPC_OFF_PENDING, 16'h0000);
      rdChk(`WPC_OFF_EDGE, 16'h0000);
      checkOuts();
      // with reset routing every active channel drives line 0
      w = 16'($urandom) | 16'h0001;
      wr(`WPC_OFF_PENDING, w);
      pend = w;
      en = 16'hFFFF;
      wr(`WPC_OFF_ENABLE, en);
      @(posedge clk);
      checkOuts();
      printVerdict();
   end
endmodule // tb_wakeup_pending_control
